/* File: rpic_pkg.sv */
package rpic_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] RPIC_ADDR_W            = 8'h08;
  localparam logic [7:0] RPIC_OFS_ENABLE_HIGH   = 8'hD8;
  localparam logic [7:0] RPIC_OFS_ENABLE_LOW    = 8'hD9;
  localparam logic [7:0] RPIC_OFS_STATUS_HIGH   = 8'hDA;
  localparam logic [7:0] RPIC_OFS_STATUS_LOW    = 8'hDB;
  localparam logic [7:0] RPIC_OFS_COND_A        = 8'hDC;
  localparam logic [7:0] RPIC_OFS_COND_B        = 8'hDD;
  localparam logic [7:0] RPIC_REG_RESET         = 8'h00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int RPIC_BIT_HI_CRC    = 0;
  localparam int RPIC_BIT_HI_ORDER  = 1;
  localparam int RPIC_BIT_HI_CODING = 2;
  localparam int RPIC_BIT_LO_LOCK   = 0;
  localparam int RPIC_BIT_LO_VALID  = 1;
  localparam int RPIC_BIT_LO_PARITY = 2;
  localparam int RPIC_FIELD_W       = 3;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rpic_req_t;

  typedef struct packed {
    logic link_coding_fault;
    logic ctrl_chan_order_fault;
    logic ctrl_chan_crc_fault;
    logic link_parity_fault;
    logic port_valid;
    logic lock;
  } rpic_evt_t;

  typedef enum logic [1:0] {
    RPIC_SYNC_IDLE = 2'b01,
    RPIC_SYNC_RUN  = 2'b10
  } rpic_sync_state_t;

endpackage

/* File: rpic_sync.sv */
`timescale 1ns/1ps
module rpic_sync #(
  parameter int WIDTH = 6
) (
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  import rpic_pkg::*;

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  // ----------------------------------------------------------------
  // Two-stage synchroniser
  // ----------------------------------------------------------------
  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;

endmodule

/* File: rpic_port_irq.sv */
// Function
// RULE_01: Enable high bit 0 lets a control-channel CRC fault raise the interrupt.
// RULE_02: Enable low bit 2 lets a link parity fault raise the interrupt.
// RULE_03: Enable low bit 1 lets any port-valid change raise the interrupt.
// RULE_04: Enable low bit 0 lets any lock change, gain or loss, raise it.
// RULE_05: Status high bit 2 flags coding faults; cleared only by reading condition B.
// RULE_06: Status high bit 1 flags control-channel order faults; cleared by reading condition A.
// RULE_07: Status high bit 0 flags control-channel CRC faults; cleared by reading condition A.
// RULE_08: Status low bit 2 flags link parity faults; cleared by reading condition A.
// RULE_09: Status low bit 1 flags port-valid changes; cleared by reading condition A.
// RULE_10: Status low bit 0 flags lock changes; cleared by reading condition A.
// RULE_11: Enable high bit 2 lets a link coding fault raise the interrupt.
// RULE_12: Enable high bit 1 lets a control-channel order fault raise the interrupt.
// RULE_13: Flags latch on detection and hold; request is any flag with its enable.
// RULE_14: Reserved status bits read zero; reset clears all enables and flags.
`timescale 1ns/1ps
module rpic_port_irq (
  input  wire logic               core_clk,
  input  wire logic               rst,
  input  wire rpic_pkg::rpic_req_t reg_req,
  input  wire rpic_pkg::rpic_evt_t link_evt,
  output logic [7:0]              reg_rdata,
  output logic                    reg_rvalid,
  output logic                    irq_req
);
  import rpic_pkg::*;

  // ----------------------------------------------------------------
  // Event capture
  // ----------------------------------------------------------------
  localparam int EVT_W = $bits(rpic_evt_t);

  logic [EVT_W-1:0] evt_raw;
  logic [EVT_W-1:0] evt_sync;
  rpic_evt_t        evt_s;
  logic             valid_prev_q;
  logic             valid_prev_d;
  logic             lock_prev_q;
  logic             lock_prev_d;
  rpic_sync_state_t sync_state_q;
  rpic_sync_state_t sync_state_d;

  assign evt_raw = link_evt;

  // Event pins come from the link receiver, outside this clock domain.
  rpic_sync #(
    .WIDTH (EVT_W)
  ) u_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .async_in (evt_raw),
    .sync_out (evt_sync)
  );

  assign evt_s = rpic_evt_t'(evt_sync);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [RPIC_FIELD_W-1:0] en_high_q;
  logic [RPIC_FIELD_W-1:0] en_high_d;
  logic [7:0]              en_low_q;
  logic [7:0]              en_low_d;
  logic [RPIC_FIELD_W-1:0] flag_high_q;
  logic [RPIC_FIELD_W-1:0] flag_high_d;
  logic [RPIC_FIELD_W-1:0] flag_low_q;
  logic [RPIC_FIELD_W-1:0] flag_low_d;
  logic [7:0]              rdata_q;
  logic [7:0]              rdata_d;
  logic                    rvalid_q;
  logic                    rvalid_d;
  logic                    irq_q;
  logic                    irq_d;
  logic [RPIC_FIELD_W-1:0] set_high;
  logic [RPIC_FIELD_W-1:0] set_low;
  logic                    clr_a;
  logic                    clr_b;

  function automatic logic [7:0] rpic_pad(input logic [RPIC_FIELD_W-1:0] f);
    rpic_pad = {{(8 - RPIC_FIELD_W){1'b0}}, f};
  endfunction

  function automatic logic hit(input rpic_req_t r, input logic [7:0] ofs);
    hit = (r.addr == ofs);
  endfunction

  always_comb begin
    valid_prev_d = evt_s.port_valid;
    lock_prev_d  = evt_s.lock;
    sync_state_d = RPIC_SYNC_RUN;
    set_high     = '0;
    set_low      = '0;
    set_high[RPIC_BIT_HI_CODING] = evt_s.link_coding_fault;      // RULE_05
    set_high[RPIC_BIT_HI_ORDER]  = evt_s.ctrl_chan_order_fault;  // RULE_06
    set_high[RPIC_BIT_HI_CRC]    = evt_s.ctrl_chan_crc_fault;    // RULE_07
    set_low[RPIC_BIT_LO_PARITY]  = evt_s.link_parity_fault;      // RULE_08
    // The first sampled level after reset is a baseline, not a change.
    if (sync_state_q == RPIC_SYNC_RUN) begin
      set_low[RPIC_BIT_LO_VALID] = evt_s.port_valid ^ valid_prev_q; // RULE_09
      set_low[RPIC_BIT_LO_LOCK]  = evt_s.lock ^ lock_prev_q;        // RULE_10
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      valid_prev_q <= 1'b0;
      lock_prev_q  <= 1'b0;
      sync_state_q <= RPIC_SYNC_IDLE;
    end else begin
      valid_prev_q <= valid_prev_d;
      lock_prev_q  <= lock_prev_d;
      sync_state_q <= sync_state_d;
    end
  end

  // ----------------------------------------------------------------
  // Register access and clear strobes
  // ----------------------------------------------------------------
  always_comb begin
    en_high_d = en_high_q;
    en_low_d  = en_low_q;
    rdata_d   = rdata_q;
    rvalid_d  = 1'b0;
    clr_a     = 1'b0;
    clr_b     = 1'b0;
    if (reg_req.wr) begin
      if (hit(reg_req, RPIC_OFS_ENABLE_HIGH)) begin
        en_high_d = reg_req.wdata[RPIC_FIELD_W-1:0];
      end else if (hit(reg_req, RPIC_OFS_ENABLE_LOW)) begin
        en_low_d = reg_req.wdata;
      end
    end else if (reg_req.rd) begin
      rvalid_d = 1'b1;
      if (hit(reg_req, RPIC_OFS_ENABLE_HIGH)) begin
        rdata_d = rpic_pad(en_high_q);
      end else if (hit(reg_req, RPIC_OFS_ENABLE_LOW)) begin
        rdata_d = en_low_q;
      end else if (hit(reg_req, RPIC_OFS_STATUS_HIGH)) begin
        rdata_d = rpic_pad(flag_high_q); // RULE_14
      end else if (hit(reg_req, RPIC_OFS_STATUS_LOW)) begin
        rdata_d = rpic_pad(flag_low_q); // RULE_14
      end else if (hit(reg_req, RPIC_OFS_COND_A)) begin
        rdata_d = rpic_pad({flag_high_q[RPIC_BIT_HI_ORDER], flag_high_q[RPIC_BIT_HI_CRC],
                            flag_low_q[RPIC_BIT_LO_LOCK]});
        clr_a   = 1'b1;
      end else if (hit(reg_req, RPIC_OFS_COND_B)) begin
        rdata_d = rpic_pad({2'b00, flag_high_q[RPIC_BIT_HI_CODING]});
        clr_b   = 1'b1;
      end else begin
        rdata_d = RPIC_REG_RESET;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      en_high_q <= '0; // RULE_14
      en_low_q  <= RPIC_REG_RESET;
      rdata_q   <= RPIC_REG_RESET;
      rvalid_q  <= 1'b0;
    end else begin
      en_high_q <= en_high_d;
      en_low_q  <= en_low_d;
      rdata_q   <= rdata_d;
      rvalid_q  <= rvalid_d;
    end
  end

  // ----------------------------------------------------------------
  // Flag update
  // ----------------------------------------------------------------
  // A new event in the clearing cycle wins, so it is never lost.
  always_comb begin
    flag_high_d = flag_high_q;
    flag_low_d  = flag_low_q;
    if (clr_a) begin
      flag_high_d[RPIC_BIT_HI_ORDER] = 1'b0; // RULE_06
      flag_high_d[RPIC_BIT_HI_CRC]   = 1'b0; // RULE_07
      flag_low_d                     = '0;   // RULE_08 RULE_09 RULE_10
    end
    if (clr_b) begin
      flag_high_d[RPIC_BIT_HI_CODING] = 1'b0; // RULE_05
    end
    flag_high_d = flag_high_d | set_high; // RULE_13
    flag_low_d  = flag_low_d | set_low;   // RULE_13
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      flag_high_q <= '0; // RULE_14
      flag_low_q  <= '0;
    end else begin
      flag_high_q <= flag_high_d;
      flag_low_q  <= flag_low_d;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt request
  // ----------------------------------------------------------------
  // Built from registered flags and enables: one cycle of latency buys a glitch-free pin.
  always_comb begin
    irq_d = |(flag_high_q & en_high_q[RPIC_FIELD_W-1:0])                // RULE_01 RULE_11 RULE_12
          | |(flag_low_q & en_low_q[RPIC_FIELD_W-1:0]);                 // RULE_02 RULE_03 RULE_04
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_d;
    end
  end

  assign reg_rdata  = rdata_q;
  assign reg_rvalid = rvalid_q;
  assign irq_req    = irq_q;

endmodule

/* File: rpic_port_irq_asserts.sv */
`timescale 1ns/1ps
module rpic_port_irq_asserts (
  input wire logic                core_clk,
  input wire logic                rst,
  input wire rpic_pkg::rpic_req_t reg_req,
  input wire rpic_pkg::rpic_evt_t link_evt,
  input wire logic [7:0]          reg_rdata,
  input wire logic                reg_rvalid,
  input wire logic                irq_req
);
  import rpic_pkg::*;
  // ----------------------------------------------------------------
  // Shadow of the enables, rebuilt from the write traffic.
  // ----------------------------------------------------------------
  logic [2:0] hi_q;
  logic [7:0] lo_q;
  logic       rd;
  logic       off;
  assign rd = reg_req.rd & ~reg_req.wr;
  assign off = (hi_q == 3'h0) && (lo_q[2:0] == 3'h0);
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      hi_q <= 3'h0;
      lo_q <= 8'h00;
    end else if (reg_req.wr && reg_req.addr == RPIC_OFS_ENABLE_HIGH) begin
      hi_q <= reg_req.wdata[2:0];
    end else if (reg_req.wr && reg_req.addr == RPIC_OFS_ENABLE_LOW) begin
      lo_q <= reg_req.wdata;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  a_read_answer: assert property (rd |=> reg_rvalid) else $error("read not answered");
  a_no_spurious: assert property (!rd |=> !reg_rvalid) else $error("stray read valid");
  a_rsvd_zero: assert property (rd && reg_req.addr inside {8'hDA, 8'hDB}
    |=> reg_rdata[7:3] == 5'h00) else $error("reserved status bits set");
  a_enable_high: assert property (rd && reg_req.addr == RPIC_OFS_ENABLE_HIGH
    |=> reg_rdata == {5'h00, $past(hi_q)}) else $error("enable high readback");
  a_enable_low: assert property (rd && reg_req.addr == RPIC_OFS_ENABLE_LOW
    |=> reg_rdata == $past(lo_q)) else $error("enable low readback");
  a_quiet_mask: assert property (off && $past(off) |-> !irq_req) else $error("masked irq");
  a_rdata_hold: assert property (!reg_rvalid |-> $stable(reg_rdata)) else $error("rdata moved");
  a_lock_irq: assert property (lo_q[0] && $changed(link_evt.lock) |-> ##[2:5] irq_req)
    else $error("lock change gave no irq");
endmodule

bind rpic_port_irq rpic_port_irq_asserts chk_u (
  .core_clk   (core_clk),
  .rst        (rst),
  .reg_req    (reg_req),
  .link_evt   (link_evt),
  .reg_rdata  (reg_rdata),
  .reg_rvalid (reg_rvalid),
  .irq_req    (irq_req)
);

/* File: rx_port_interrupt_ctrl_tb.sv */
`timescale 1ns/1ps
module rx_port_interrupt_ctrl_tb;
  import rpic_pkg::*;
  logic       core_clk = 1'b0;
  logic       rst = 1'b1;
  rpic_req_t  req = '0;
  rpic_evt_t  evt = '0;
  logic [7:0] rdata;
  logic       rvalid;
  logic       irq;
  int         mismatches = 0;
  int         samples_checked = 0;
  int         en_hi = 0, en_lo = 0, fl_hi = 0, fl_lo = 0, v;
  always #20 core_clk = ~core_clk;
  rpic_port_irq dut_u (.core_clk(core_clk), .rst(rst), .reg_req(req), .link_evt(evt),
    .reg_rdata(rdata), .reg_rvalid(rvalid), .irq_req(irq));
  // ----------------------------------------------------------------
  // Shared bus cycles and comparisons.
  // ----------------------------------------------------------------
  task automatic cmp(input string n, input int e, input logic [7:0] s);
    samples_checked++;
    if (s !== 8'(e)) begin
      mismatches++;
      $display("unexpected %s expected %0h seen %0h", n, e, s);
    end
  endtask
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk) #1;
    req = {w, ~w, a, d};
    @(posedge core_clk) #1;
    req = '0;
    if (!w) cmp("rvalid", 1, {7'h00, rvalid});
  endtask
  task automatic rchk(input logic [7:0] a, input int e);
    acc(1'b0, a, 8'h00);
    cmp("rdata", e, rdata);
  endtask
  // Settling covers the two-flop input synchroniser plus the flag and request stages.
  task automatic ichk(input int n);
    repeat (n) @(posedge core_clk);
    #1 cmp("irq", ((fl_hi & en_hi) | (fl_lo & en_lo)) != 0, {7'h00, irq});
  endtask
  task automatic finish_test();
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    #200us;
    mismatches++;
    finish_test();
  end
  initial begin
    void'($urandom(60683));
    repeat (16) @(posedge core_clk);
    #1 rst = 1'b0;
    for (int k = 0; k < 4; k++) rchk(RPIC_OFS_ENABLE_HIGH + 8'(k), 0);
    acc(1'b1, RPIC_OFS_STATUS_HIGH, 8'hFF);
    acc(1'b1, RPIC_OFS_STATUS_LOW, 8'hFF);
    rchk(RPIC_OFS_STATUS_HIGH, 0);
    rchk(8'hE0, 0);
    for (int i = 0; i < 40; i++) begin
      v = $urandom;
      acc(1'b1, RPIC_OFS_ENABLE_HIGH, v[7:0]);
      acc(1'b1, RPIC_OFS_ENABLE_LOW, v[15:8]);
      en_hi = v & 7;
      en_lo = (v >> 8) & 255;
      v = $urandom;
      evt = {v[5:2], evt.port_valid ^ v[1], evt.lock ^ v[0]};
      fl_hi |= (v >> 3) & 7;
      fl_lo |= v & 7;
      @(posedge core_clk) #1;
      evt = {4'h0, evt.port_valid, evt.lock};
      ichk(7);
      rchk(RPIC_OFS_STATUS_HIGH, fl_hi);
      rchk(RPIC_OFS_STATUS_LOW, fl_lo);
      rchk(RPIC_OFS_ENABLE_HIGH, en_hi);
      rchk(RPIC_OFS_ENABLE_LOW, en_lo);
      if (v[6]) begin
        rchk(RPIC_OFS_COND_A, ((fl_hi & 3) << 1) | (fl_lo & 1));
        fl_lo = 0;
        fl_hi &= 4;
      end else begin
        rchk(RPIC_OFS_COND_B, fl_hi >> 2);
        fl_hi &= 3;
      end
      ichk(3);
    end
    // Mid-run reset with flags and a request standing: all must fall to zero.
    acc(1'b1, RPIC_OFS_ENABLE_HIGH, 8'hFF);
    en_hi = 7;
    evt = '1;
    fl_hi |= 7;
    fl_lo |= 7;
    @(posedge core_clk) #1;
    evt = '0;
    ichk(7);
    rst = 1'b1;
    repeat (2) @(posedge core_clk);
    #1 cmp("irq", 0, {7'h00, irq});
    rst = 1'b0;
    en_hi = 0;
    en_lo = 0;
    fl_hi = 0;
    fl_lo = 0;
    for (int k = 0; k < 4; k++) rchk(RPIC_OFS_ENABLE_HIGH + 8'(k), 0);
    ichk(2);
    finish_test();
  end
endmodule
